// ---- hw/sjsse_pkg.sv ----
// Shared constants and types for the shift/jump/store/subtract executor
package sjsse_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_INSTR  = 8'h04;
  localparam logic [7:0] A_OPA    = 8'h08;
  localparam logic [7:0] A_OPB    = 8'h0C;
  localparam logic [7:0] A_PC     = 8'h10;
  localparam logic [7:0] A_RESULT = 8'h14;
  localparam logic [7:0] A_PSW    = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;

  // Field positions
  localparam int CTRL_GO     = 0;
  localparam int CTRL_MODE1M = 1;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_BAD    = 1;
  localparam int PSW_ST      = 0;
  localparam int PSW_C       = 1;
  localparam int PSW_VT      = 2;
  localparam int PSW_V       = 3;
  localparam int PSW_N       = 4;
  localparam int PSW_Z       = 5;

  // Reset values
  localparam logic [5:0]  PSW_RST = 6'h00;
  localparam logic [23:0] PC_RST  = 24'h000000;

  // Opcodes and opcode prefixes
  localparam logic [7:0] OP_SHIFT_LONG = 8'h0C;
  localparam logic [7:0] OP_SKIP       = 8'h00;
  localparam logic [4:0] OP_JUMP_PFX   = 5'h04;
  localparam logic [5:0] OP_STW_PFX    = 6'h30;
  localparam logic [5:0] OP_STB_PFX    = 6'h31;
  localparam logic [5:0] OP_SUB2_PFX   = 6'h1A;
  localparam logic [5:0] OP_SUB3_PFX   = 6'h12;

  // Shift count limits
  localparam logic [7:0]  CNT_REG_LOW = 8'h10;
  localparam logic [31:0] CNT_REG_MAX = 32'h0000001F;

  typedef enum logic [1:0] {
    SJSSE_IDLE  = 2'b01,
    SJSSE_SHIFT = 2'b10
  } sjsse_state_t;
endpackage : sjsse_pkg

// ---- hw/sjsse_shifter.sv ----
// Multi-cycle logical right shifter for a double word, one step per clock
module sjsse_shifter
  import sjsse_pkg::*;
(
  input  wire logic        clock,      // Core clock
  input  wire logic        rstn,       // Async reset, active low
  input  wire logic        load,       // Start a shift
  input  wire logic [31:0] din,        // Operand to shift
  input  wire logic [4:0]  cnt_in,     // Shift count
  input  wire logic        c_in,       // Carry before the shift
  output logic             active,     // Shift in progress
  output logic             done,       // Last cycle of the shift
  output logic [4:0]       cnt_left,   // Steps still to do
  output logic [31:0]      dout,       // Shifted value
  output logic             carry,      // Carry out
  output logic             sticky      // Sticky out
);
  logic        active_ff;
  logic        stepped_ff;
  logic [4:0]  cnt_ff;
  logic [31:0] val_ff;
  logic        carry_ff;
  logic        sticky_ff;
  logic        step;

  assign step     = active_ff && (cnt_ff != 5'h00);
  assign active   = active_ff;
  assign done     = active_ff && (cnt_ff == 5'h00);
  assign cnt_left = cnt_ff;
  assign dout     = val_ff;
  assign carry    = carry_ff;
  assign sticky   = sticky_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      active_ff  <= 1'b0;
      stepped_ff <= 1'b0;
      cnt_ff     <= 5'h00;
      val_ff     <= 32'h00000000;
      carry_ff   <= 1'b0;
      sticky_ff  <= 1'b0;
    end else if (load) begin
      active_ff  <= 1'b1;
      stepped_ff <= 1'b0;
      cnt_ff     <= cnt_in;
      val_ff     <= din;
      carry_ff   <= c_in;
      sticky_ff  <= 1'b0;
    end else if (step) begin
      val_ff     <= {1'b0, val_ff[31:1]};
      carry_ff   <= val_ff[0];
      // Old carry only counts once it came from this shift
      sticky_ff  <= sticky_ff | (carry_ff & stepped_ff);
      stepped_ff <= 1'b1;
      cnt_ff     <= cnt_ff - 5'h01;
    end else begin
      active_ff  <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_step_count: assert property (step && !load |=> cnt_ff == $past(cnt_ff) - 5'h01)
    else $error("shift count did not drop by one");
  a_zero_fill: assert property (step && !load |=> !val_ff[31])
    else $error("shift did not fill with zero");
  a_carry_out: assert property (step && !load |=> carry_ff == $past(val_ff[0]))
    else $error("carry is not the bit shifted out");
  a_sticky_clear: assert property (load |=> !sticky_ff)
    else $error("sticky not cleared at shift start");
  a_sticky_set: assert property (step && !load && carry_ff && stepped_ff |=> sticky_ff)
    else $error("sticky not set after a one left carry");
endmodule : sjsse_shifter

// ---- hw/sjsse_sub.sv ----
// Word subtractor with flag outputs
module sjsse_sub
  import sjsse_pkg::*;
(
  input  wire logic [15:0] a,     // Minuend
  input  wire logic [15:0] b,     // Subtrahend
  output logic [15:0]      diff,  // a - b
  output logic             z,     // Zero
  output logic             n,     // Negative
  output logic             c,     // Not borrow
  output logic             v      // Signed overflow
);
  logic [16:0] wide;

  assign wide = {1'b0, a} - {1'b0, b};
  assign diff = wide[15:0];
  assign z    = (wide[15:0] == 16'h0000);
  assign n    = wide[15];
  assign c    = !wide[16];
  assign v    = (a[15] ^ b[15]) & (a[15] ^ wide[15]);
endmodule : sjsse_sub

// ---- hw/sjsse_top.sv ----
// Executor for shift-long, short jump, skip, store and word subtract
// Summary of operation
// - Logical right shift of a double word moves it one place per step.
// - Immediate shift count is zero to fifteen, held in the instruction.
// - Register count comes from locations 10H-0FFH and must be 0 to 31.
// - Shift fills vacated high bits with zeros.
// - Carry holds the last bit shifted out at the low end.
// - Shift clears sticky before its first step.
// - Sticky sets when a one shifted into carry by this shift is followed by another step.
// - Short jump adds a signed 11-bit distance, least value minus 1024.
// - Jump distance widens to 16 bits or 24 bits by addressing mode.
// - In 1-Mbyte mode the jump may carry into upper address bits.
// - Two-byte no-op ignores its second byte and changes nothing.
// - Store word copies the source word register to the destination.
// - Store byte copies the source byte register to the destination.
// - Two-operand subtract writes destination minus source to destination.
// - Subtract carry is the inverse of borrow.
// - Three-operand subtract writes first minus second source to a new word.
// - Three-operand subtract opcode 010010aa, then operand, source, destination.
module sjsse_top
  import sjsse_pkg::*;
(
  input  wire logic        clock,      // Core clock, 10 MHz
  input  wire logic        rstn,       // Async reset, active low
  input  wire logic        hsel,       // AHB slave select
  input  wire logic [31:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size, word only
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hready,     // AHB bus ready
  output logic             hreadyout,  // AHB slave ready
  output logic [31:0]      hrdata,     // AHB read data
  output logic             hresp       // AHB response, always OKAY
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus slave phases
  logic        dp_wr_ff;
  logic        dp_rd_ff;
  logic        rd_done_ff;
  logic [7:0]  dp_addr_ff;
  logic [31:0] hrdata_ff;
  logic        ap;
  logic        wr;

  assign ap        = hsel && hready && htrans[1];
  assign wr        = dp_wr_ff;
  // One wait state on reads so data comes from a flop and sees any prior write
  assign hreadyout = !(dp_rd_ff && !rd_done_ff);
  assign hrdata    = hrdata_ff;
  assign hresp     = 1'b0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dp_wr_ff   <= 1'b0;
      dp_rd_ff   <= 1'b0;
      dp_addr_ff <= 8'h00;
    end else if (hready) begin
      dp_wr_ff   <= ap && hwrite;
      dp_rd_ff   <= ap && !hwrite;
      dp_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_done_ff <= 1'b0;
    end else begin
      rd_done_ff <= dp_rd_ff && !rd_done_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic               mode1m_ff;
  logic [15:0]        instr_ff;
  logic [31:0]        opa_ff;
  logic [31:0]        opb_ff;
  logic [23:0]        pc_ff;
  logic [31:0]        result_ff;
  logic [5:0]         psw_ff;
  logic               bad_ff;
  sjsse_state_t       state_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode1m_ff <= 1'b0;
      instr_ff  <= 16'h0000;
      opa_ff    <= 32'h00000000;
      opb_ff    <= 32'h00000000;
    end else if (wr) begin
      if (dp_addr_ff == A_CTRL) mode1m_ff <= hwdata[CTRL_MODE1M];
      if (dp_addr_ff == A_INSTR) instr_ff <= hwdata[15:0];
      if (dp_addr_ff == A_OPA) opa_ff <= hwdata;
      if (dp_addr_ff == A_OPB) opb_ff <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [7:0]  op;
  logic [7:0]  byte2;
  logic        go;
  logic        is_shift;
  logic        is_skip;
  logic        is_jump;
  logic        is_stw;
  logic        is_stb;
  logic        is_sub2;
  logic        is_sub3;
  logic        is_sub;
  logic        cnt_is_reg;
  logic        cnt_bad;
  logic        illegal;
  logic [4:0]  count;
  logic [10:0] disp;
  logic [23:0] disp24;
  logic [15:0] disp16;

  assign op    = instr_ff[7:0];
  assign byte2 = instr_ff[15:8];
  assign go    = wr && (dp_addr_ff == A_CTRL) && hwdata[CTRL_GO]
                 && (state_ff == SJSSE_IDLE);

  assign is_shift = (op == OP_SHIFT_LONG);
  assign is_skip  = (op == OP_SKIP);
  assign is_jump  = (op[7:3] == OP_JUMP_PFX);
  assign is_stw   = (op[7:2] == OP_STW_PFX);
  assign is_stb   = (op[7:2] == OP_STB_PFX);
  assign is_sub2  = (op[7:2] == OP_SUB2_PFX);
  assign is_sub3  = (op[7:2] == OP_SUB3_PFX);
  assign is_sub   = is_sub2 || is_sub3;

  // Second byte below 10H is an immediate count, else a register location
  assign cnt_is_reg = (byte2 >= CNT_REG_LOW);
  assign cnt_bad    = cnt_is_reg && (opb_ff > CNT_REG_MAX);
  assign count      = cnt_is_reg ? opb_ff[4:0] : {1'b0, byte2[3:0]};
  assign illegal    = (is_shift && cnt_bad)
                      || !(is_shift || is_skip || is_jump || is_stw
                           || is_stb || is_sub);

  // Low three opcode bits are the top of an 11-bit signed distance
  assign disp   = {op[2:0], byte2};
  assign disp16 = {{5{disp[10]}}, disp};
  assign disp24 = {{13{disp[10]}}, disp};

  ////////////////////////////////////////////////////////////////////////////
  // Datapath units
  logic        sh_load;
  logic        sh_active;
  logic        sh_done;
  logic [4:0]  sh_cnt;
  logic [31:0] sh_val;
  logic        sh_carry;
  logic        sh_sticky;
  logic [15:0] sub_diff;
  logic        sub_z;
  logic        sub_n;
  logic        sub_c;
  logic        sub_v;

  assign sh_load = go && is_shift && !cnt_bad;

  sjsse_shifter u_shifter (
    .clock    (clock),
    .rstn     (rstn),
    .load     (sh_load),
    .din      (opa_ff),
    .cnt_in   (count),
    .c_in     (psw_ff[PSW_C]),
    .active   (sh_active),
    .done     (sh_done),
    .cnt_left (sh_cnt),
    .dout     (sh_val),
    .carry    (sh_carry),
    .sticky   (sh_sticky)
  );

  // Both forms compute first operand register minus second
  sjsse_sub u_sub (
    .a    (opa_ff[15:0]),
    .b    (opb_ff[15:0]),
    .diff (sub_diff),
    .z    (sub_z),
    .n    (sub_n),
    .c    (sub_c),
    .v    (sub_v)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SJSSE_IDLE;
    end else begin
      unique case (state_ff)
        SJSSE_IDLE:  if (sh_load) state_ff <= SJSSE_SHIFT;
        SJSSE_SHIFT: if (sh_done) state_ff <= SJSSE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bad_ff <= 1'b0;
    end else if (go) begin
      bad_ff <= illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results, flags and program counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_ff <= 32'h00000000;
    end else if (sh_done) begin
      result_ff <= sh_val;
    end else if (go && is_sub) begin
      result_ff <= {16'h0000, sub_diff};
    end else if (go && is_stw) begin
      result_ff <= {16'h0000, opb_ff[15:0]};
    end else if (go && is_stb) begin
      result_ff <= {24'h000000, opb_ff[7:0]};
    end
  end

  // Hardware update wins over a software write in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      psw_ff <= PSW_RST;
    end else if (sh_done) begin
      psw_ff[PSW_Z]  <= (sh_val == 32'h00000000);
      psw_ff[PSW_N]  <= 1'b0;
      psw_ff[PSW_V]  <= 1'b0;
      psw_ff[PSW_C]  <= sh_carry;
      psw_ff[PSW_ST] <= sh_sticky;
    end else if (go && is_sub) begin
      psw_ff[PSW_Z]  <= sub_z;
      psw_ff[PSW_N]  <= sub_n;
      psw_ff[PSW_V]  <= sub_v;
      psw_ff[PSW_C]  <= sub_c;
      psw_ff[PSW_VT] <= psw_ff[PSW_VT] | sub_v;
    end else if (wr && (dp_addr_ff == A_PSW)) begin
      psw_ff <= hwdata[5:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc_ff <= PC_RST;
    end else if (go && is_jump) begin
      if (mode1m_ff) begin
        pc_ff <= pc_ff + disp24;
      end else begin
        pc_ff[15:0] <= pc_ff[15:0] + disp16;
      end
    end else if (wr && (dp_addr_ff == A_PC)) begin
      pc_ff <= hwdata[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hrdata_ff <= 32'h00000000;
    end else if (dp_rd_ff && !rd_done_ff) begin
      unique case (dp_addr_ff)
        A_CTRL:   hrdata_ff <= {30'h00000000, mode1m_ff, 1'b0};
        A_INSTR:  hrdata_ff <= {16'h0000, instr_ff};
        A_OPA:    hrdata_ff <= opa_ff;
        A_OPB:    hrdata_ff <= opb_ff;
        A_PC:     hrdata_ff <= {8'h00, pc_ff};
        A_RESULT: hrdata_ff <= result_ff;
        A_PSW:    hrdata_ff <= {26'h0000000, psw_ff};
        A_STATUS: hrdata_ff <= {30'h00000000, bad_ff, sh_active};
        default:  hrdata_ff <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_go_imm;
    go && is_shift && !cnt_is_reg;
  endsequence
  sequence s_go_sub;
    go && is_sub;
  endsequence
  sequence s_go_store;
    go && (is_stw || is_stb);
  endsequence
  sequence s_go_jump;
    go && is_jump;
  endsequence

  a_imm_count: assert property (s_go_imm |=> sh_cnt == {1'b0, $past(byte2[3:0])})
    else $error("immediate count not taken from instruction");
  a_reg_count: assert property (go && is_shift && cnt_is_reg && opb_ff > CNT_REG_MAX
                                |=> bad_ff && state_ff == SJSSE_IDLE)
    else $error("register count above 31 was not refused");
  a_jump_short: assert property (s_go_jump ##0 !mode1m_ff
                                 |=> pc_ff[23:16] == $past(pc_ff[23:16]))
    else $error("64K jump changed upper address bits");
  a_jump_long: assert property (s_go_jump ##0 mode1m_ff
                                |=> pc_ff - $past(pc_ff) == $past(disp24))
    else $error("1M jump distance wrong");
  a_skip_still: assert property (go && is_skip
                                 |=> $stable(psw_ff) && $stable(pc_ff)
                                     && $stable(result_ff))
    else $error("skip changed state");
  a_store_flags: assert property (s_go_store |=> $stable(psw_ff))
    else $error("store changed flags");
  a_store_data: assert property (go && is_stb |=> result_ff == {24'h000000, $past(opb_ff[7:0])})
    else $error("byte store data wrong");
  a_sub_diff: assert property (s_go_sub |=> result_ff[15:0] + $past(opb_ff[15:0])
                                            == $past(opa_ff[15:0]))
    else $error("subtract result wrong");
  a_sub_carry: assert property (s_go_sub |=> psw_ff[PSW_C]
                                == ($past(opa_ff[15:0]) >= $past(opb_ff[15:0])))
    else $error("subtract carry is not inverse borrow");
  a_sub_sticky: assert property (s_go_sub |=> psw_ff[PSW_ST] == $past(psw_ff[PSW_ST]))
    else $error("subtract changed sticky");
  a_shift_flags: assert property (sh_done |=> !psw_ff[PSW_N] && !psw_ff[PSW_V]
                                  && state_ff == SJSSE_IDLE)
    else $error("shift left N or V set");
endmodule : sjsse_top

// ---- test/sjsse_tb_top.sv ----
// Self-checking bench for the shift, jump, store and subtract executor
module sjsse_tb_top
  import sjsse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        mode1m;
  int          num_errors;
  int          checks_done;

  sjsse_top uut (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  initial begin
    clock = 1'h0;
  end
  always #50 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Bounded so a slave that never answers is reported instead of hanging
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'h1 && n < 16);
    chk({31'h0, hreadyout}, 32'h1, "ready");
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp, msg);
  endtask : rd

  // Loads one instruction, starts it and waits until it is no longer busy
  task automatic run_op(input logic [15:0] ins, input logic [31:0] a, input logic [31:0] b,
                        output logic [31:0] st);
    wr(A_INSTR, {16'h0, ins});
    wr(A_OPA, a);
    wr(A_OPB, b);
    wr(A_CTRL, {30'h0, mode1m, 1'h1});
    repeat (40) begin
      bus(1'h0, A_STATUS, 32'h0, st);
      if (st[STAT_BUSY] === 1'h0) break;
    end
    chk({31'h0, st[STAT_BUSY]}, 32'h0, "busy cleared");
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(A_PSW, 32'h0, "psw reset");
    rd(A_PC, 32'h0, "pc reset");
    rd(A_STATUS, 32'h0, "status reset");
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, "unmapped");
  endtask : t_reset

  task automatic sh_case(input logic [7:0] b2, input logic [31:0] v, input logic [31:0] ob,
                         input logic c0, input int n);
    logic [31:0] r;
    logic [31:0] s;
    logic        c;
    logic        st;
    r = v;
    c = c0;
    st = 1'h0;
    for (int i = 0; i < n; i++) begin
      if (i > 0 && c) st = 1'h1;
      c = r[0];
      r = r >> 1;
    end
    wr(A_PSW, {27'h0, 3'h7, c0, 1'h1});
    run_op({b2, OP_SHIFT_LONG}, v, ob, s);
    chk({31'h0, s[STAT_BAD]}, 32'h0, "shift accepted");
    rd(A_RESULT, r, "shift result");
    rd(A_PSW, {26'h0, r == 32'h0, 2'h0, 1'h1, c, st}, "shift flags");
  endtask : sh_case

  task automatic t_shift;
    logic [31:0] s;
    sh_case(8'h0F, 32'h8001_0003, 32'h0, 1'h0, 15);
    sh_case(8'h00, 32'h0, 32'h0, 1'h1, 0);
    sh_case(8'h10, 32'hFFFF_FFFF, 32'h1F, 1'h0, 31);
    sh_case(8'hFF, 32'h3, 32'h1, 1'h1, 1);
    sh_case(8'h12, 32'hF0F0_0001, 32'h4, 1'h0, 4);
    wr(A_PSW, 32'h0);
    run_op({8'h10, OP_SHIFT_LONG}, 32'h1, 32'h20, s);
    chk({31'h0, s[STAT_BAD]}, 32'h1, "count above 31 refused");
    rd(A_PSW, 32'h0, "refused shift keeps flags");
  endtask : t_shift

  task automatic jmp_case(input logic m, input logic [23:0] pc0, input logic [2:0] dh,
                          input logic [7:0] dl, input logic [23:0] exp);
    logic [31:0] s;
    mode1m = m;
    // Mode must be in place before go: the go write still sees the old mode
    wr(A_CTRL, {30'h0, m, 1'h0});
    wr(A_PC, {8'h0, pc0});
    wr(A_PSW, 32'h2A);
    run_op({dl, OP_JUMP_PFX, dh}, 32'h0, 32'h0, s);
    rd(A_PC, {8'h0, exp}, "jump target");
    rd(A_PSW, 32'h2A, "jump keeps flags");
  endtask : jmp_case

  task automatic t_jump;
    jmp_case(1'h0, 24'h12_0010, 3'h4, 8'h00, 24'h12_FC10);
    jmp_case(1'h1, 24'h12_0010, 3'h4, 8'h00, 24'h11_FC10);
    jmp_case(1'h1, 24'h0F_FF00, 3'h3, 8'hFF, 24'h10_02FF);
    jmp_case(1'h0, 24'h05_FF00, 3'h3, 8'hFF, 24'h05_02FF);
    mode1m = 1'h0;
  endtask : t_jump

  task automatic t_store;
    logic [31:0] s;
    wr(A_PSW, 32'h33);
    for (int aa = 0; aa < 4; aa++) begin
      run_op({8'h00, OP_STW_PFX, 2'(aa)}, 32'h0, 32'hA5A5_1234, s);
      rd(A_RESULT, 32'h1234, "store word");
      run_op({8'h00, OP_STB_PFX, 2'(aa)}, 32'h0, 32'hA5A5_1234 + aa, s);
      rd(A_RESULT, 32'h34 + aa, "store byte");
    end
    rd(A_PSW, 32'h33, "store keeps flags");
    run_op({8'hFF, OP_SKIP}, 32'h5, 32'h6, s);
    chk({31'h0, s[STAT_BAD]}, 32'h0, "skip accepted");
    rd(A_RESULT, 32'h37, "skip keeps result");
    rd(A_PSW, 32'h33, "skip keeps flags");
    run_op({8'h00, 8'h01}, 32'h5, 32'h6, s);
    chk({31'h0, s[STAT_BAD]}, 32'h1, "undefined opcode refused");
    rd(A_RESULT, 32'h37, "undefined opcode keeps result");
    rd(A_PSW, 32'h33, "undefined opcode keeps flags");
  endtask : t_store

  task automatic sub_case(input logic [5:0] pfx, input logic [15:0] a, input logic [15:0] b,
                          input logic [5:0] p0);
    logic [15:0] d;
    logic        v;
    logic [31:0] s;
    d = a - b;
    v = (a[15] != b[15]) && (d[15] != a[15]);
    wr(A_PSW, {26'h0, p0});
    run_op({8'h00, pfx, 2'h1}, {16'hFFFF, a}, {16'hFFFF, b}, s);
    rd(A_RESULT, {16'h0, d}, "difference");
    rd(A_PSW, {26'h0, d == 16'h0, d[15], v, p0[PSW_VT] | v, a >= b, p0[PSW_ST]},
       "subtract flags");
  endtask : sub_case

  task automatic t_sub;
    sub_case(OP_SUB2_PFX, 16'h0005, 16'h0003, 6'h01);
    sub_case(OP_SUB2_PFX, 16'h0003, 16'h0005, 6'h00);
    sub_case(OP_SUB2_PFX, 16'h8000, 16'h0001, 6'h01);
    sub_case(OP_SUB3_PFX, 16'h0007, 16'h0007, 6'h05);
    sub_case(OP_SUB3_PFX, 16'h7FFF, 16'hFFFF, 6'h00);
    sub_case(OP_SUB3_PFX, 16'h1000, 16'h2345, 6'h04);
  endtask : t_sub

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mode1m = 1'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    t_reset();
    t_shift();
    t_jump();
    t_store();
    t_sub();
    stop_test();
  end

  // A full run takes under a thousand cycles; this leaves wide margin
  initial begin
    #3_000_000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : sjsse_tb_top
